// ### src/ctd_pkg.sv
// Shared constants, field layouts and types of the touch detector.
// Assumes a 100 MHz reference clock and a 32-bit Avalon-MM register bus.
package ctd_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 500_000;
  localparam int TICK_CYCLES = CLK_HZ / OSC_HZ;
  // ==========================================================
  // Datapath widths
  localparam int SIG_W = 16;
  localparam int FRAC_W = 4;
  localparam int FILT_SHIFT = 4;
  localparam int CAL_BURSTS = 32;
  localparam int DEB_W = 8;
  localparam int ADDR_W = 5;
  // ==========================================================
  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_CONFIG = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_SIGNAL = 5'h08;
  localparam logic [ADDR_W-1:0] REG_REFERENCE = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_DEBOUNCE = 5'h10;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [DEB_W-1:0] DDC_RESET = 8'h03;
  localparam logic [DEB_W-1:0] EXIT_DEBOUNCE_COUNT_RESET = 8'h04;
  localparam int DDC_LSB = 0;
  localparam int EXIT_DEBOUNCE_COUNT_LSB = 8;
  localparam int ST_DETECT = 0;
  localparam int ST_CAL = 1;
  localparam int ST_THAW = 2;
  // ==========================================================
  // Thresholds, sampling gaps and freeze limits
  localparam int THR_REL_SH0 = 3;
  localparam int THR_REL_SH1 = 4;
  localparam logic [SIG_W-1:0] THR_ABS0 = 16'h0008;
  localparam logic [SIG_W-1:0] THR_ABS1 = 16'h0004;
  localparam logic [SIG_W-1:0] GAP_NORMAL = 16'h0004;
  localparam logic [SIG_W-1:0] GAP_LP1 = 16'h0040;
  localparam logic [SIG_W-1:0] GAP_LP2 = 16'h0100;
  localparam logic [SIG_W-1:0] GAP_LP3 = 16'h0400;
  localparam logic [SIG_W-1:0] FRZ_LIM0 = 16'h0020;
  localparam logic [SIG_W-1:0] FRZ_LIM1 = 16'h0080;
  localparam logic [SIG_W-1:0] FRZ_LIM2 = 16'h0200;
  localparam logic [SIG_W-1:0] FRZ_LIM3 = 16'h0800;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_TOUCH = 2'h0, MODE_PROX = 2'h1, MODE_RSV2 = 2'h2, MODE_RSV3 = 2'h3
  } ctd_mode_t;
  typedef struct packed {
    logic [1:0] power;
    logic [1:0] thr;
    logic [1:0] freeze;
    ctd_mode_t mode;
  } ctd_cfg_t;
  typedef struct packed {
    logic discharge;
    logic charge;
    logic transfer;
  } ctd_fe_t;
  typedef enum logic [1:0] {
    SQ_LAUNCH = 2'h0, SQ_BURST = 2'h1, SQ_UPDATE = 2'h3, SQ_GAP = 2'h2
  } ctd_seq_t;
  typedef enum logic [1:0] {
    BU_IDLE = 2'h0, BU_CHARGE = 2'h1, BU_XFER = 2'h3
  } ctd_burst_t;
  // Oscillator ticks between bursts per power setting
  function automatic logic [SIG_W-1:0] gap_ticks(input logic [1:0] pm);
    case (pm)
      2'h0: gap_ticks = GAP_NORMAL;
      2'h1: gap_ticks = GAP_LP1;
      2'h2: gap_ticks = GAP_LP2;
      default: gap_ticks = GAP_LP3;
    endcase
  endfunction
  // Samples a detection may hold the reference frozen
  function automatic logic [SIG_W-1:0] freeze_limit(input logic [1:0] fs);
    case (fs)
      2'h0: freeze_limit = FRZ_LIM0;
      2'h1: freeze_limit = FRZ_LIM1;
      2'h2: freeze_limit = FRZ_LIM2;
      default: freeze_limit = FRZ_LIM3;
    endcase
  endfunction
endpackage

// ### src/ctd_burst.sv
// Burst engine: runs charge/transfer cycles and counts them.
// Assumes the front end compares the sampling capacitor asynchronously.
module ctd_burst #(
  parameter int CNT_W = ctd_pkg::SIG_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic start,
  input wire logic trip_level_in,
  output ctd_pkg::ctd_fe_t fe,
  output logic done,
  output logic [CNT_W-1:0] count
);
  import ctd_pkg::*;

  if (CNT_W < 4) begin : g_chk
    $error("ctd_burst: CNT_W too small");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  ctd_burst_t state;
  logic trip_meta;
  logic trip_s;
  wire cycle_end = (state == BU_XFER) && tick;
  wire [CNT_W-1:0] count_inc = count + 1'b1;
  // Stop one short of wrapping so a stuck comparator saturates the count
  wire stop = trip_s || (count_inc == CNT_MAX);

  // ==========================================================
  // Comparator synchroniser
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_meta <= 1'b0;
      trip_s <= 1'b0;
    end else begin
      trip_meta <= trip_level_in;
      trip_s <= trip_meta;
    end
  end

  // ==========================================================
  // Cycle sequencer and counter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= BU_IDLE;
      count <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        BU_IDLE: begin
          if (start) begin
            count <= '0;
            state <= BU_CHARGE;
          end
        end
        BU_CHARGE: begin
          if (tick) state <= BU_XFER;
        end
        BU_XFER: begin
          if (tick) begin
            count <= count_inc;
            if (stop) begin
              state <= BU_IDLE;
              done <= 1'b1;
            end else begin
              state <= BU_CHARGE;
            end
          end
        end
        default: state <= BU_IDLE;
      endcase
    end
  end

  // Front end drive follows the phase
  assign fe.discharge = (state == BU_IDLE);
  assign fe.charge = (state == BU_CHARGE);
  assign fe.transfer = (state == BU_XFER);

  // ==========================================================
  // Checks
  AST_BURST_STOP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cycle_end && trip_s) |=> (state == BU_IDLE) && done)
    else $error("burst did not end on trip");
  AST_BURST_GO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cycle_end && !stop) |=> (state == BU_CHARGE) && !done)
    else $error("burst ended before trip");
endmodule // ctd_burst

// ### src/ctd_debounce.sv
// Debounce of the detection candidate over consecutive samples.
// Assumes one sample strobe per acquisition from the same clock.
module ctd_debounce #(
  parameter int CNT_W = ctd_pkg::DEB_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sample,
  input wire logic cond,
  input wire logic [CNT_W-1:0] entry_need,
  input wire logic [CNT_W-1:0] exit_need,
  output logic active
);
  import ctd_pkg::*;

  if (CNT_W < 1) begin : g_chk
    $error("ctd_debounce: CNT_W must be positive");
  end

  logic [CNT_W-1:0] run;
  wire [CNT_W:0] run_next = {1'b0, run} + 1'b1;
  wire [CNT_W-1:0] need = active ? exit_need : entry_need;
  wire flip = run_next >= {1'b0, need};

  // ==========================================================
  // Count samples that disagree with the reported state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run <= '0;
      active <= 1'b0;
    end else if (sample) begin
      if (cond != active) begin
        if (flip) begin
          active <= ~active;
          run <= '0;
        end else begin
          run <= run_next[CNT_W-1:0];
        end
      end else begin
        run <= '0;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_DEB_ENTRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sample && !active && cond && flip) |=> active)
    else $error("entry count reached but no detection");
  AST_DEB_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sample && !active && (!cond || !flip)) |=> !active)
    else $error("detection entered too early");
  AST_DEB_EXIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sample && active && !cond && !flip) |=> active)
    else $error("detection left too early");
endmodule // ctd_debounce

// ### src/ctd_top.sv
// Capacitive touch detector: acquisition, calibration, drift filter,
// detection and the Avalon-MM register slave.
// Assumes an analog charge-transfer front end with an async comparator.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
import ctd_pkg::*;

// How it works
// - Transfer cycles repeat until comparator trips
// - Cycle count per burst is the signal
// - Reference from 32 bursts before detection
// - Calibration always uses normal power gaps
// - Configured low power applies after calibration
// - Candidate when reference minus signal reaches threshold
// - Consecutive samples needed before state changes
// - Four thresholds: two relative, two absolute
// - Reference updated by unity gain IIR
// - Reference tracks slow drift of signal
// - Reported detection freezes the reference
// - Config bits 1:0 select touch or proximity
// - Freeze timeout re-enables filter during detection
// - Detect output high while detection reported
// - Separate entry and exit debounce counts
// - Sequencing paced by 500 kHz oscillator tick
module ctd_top #(
  parameter int CAL_COUNT = ctd_pkg::CAL_BURSTS
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ctd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output ctd_pkg::ctd_fe_t fe,
  input wire logic trip_level_in,
  output logic detect_output
);
  import ctd_pkg::*;

  localparam int CAL_SH = $clog2(CAL_COUNT);
  localparam int ACC_W = SIG_W + FRAC_W;
  localparam int SUM_W = SIG_W + CAL_SH;
  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [CAL_SH-1:0] CAL_LAST = CAL_SH'(CAL_COUNT - 1);

  if (CAL_COUNT < 2 || (1 << CAL_SH) != CAL_COUNT) begin : g_chk
    $error("ctd_top: CAL_COUNT must be a power of two, at least 2");
  end

  // ==========================================================
  // Declarations
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic ack;
  ctd_cfg_t cfg;
  logic [DEB_W-1:0] ddc;
  logic [DEB_W-1:0] exit_debounce_count;
  ctd_seq_t sq;
  ctd_seq_t next_sq;
  logic [SIG_W-1:0] gap_cnt;
  logic [SIG_W-1:0] sig;
  logic [ACC_W-1:0] ref_acc;
  logic [SUM_W-1:0] cal_sum;
  logic [CAL_SH-1:0] cal_n;
  logic calibrating;
  logic [SIG_W-1:0] frz_cnt;
  logic thaw;
  logic detected;
  logic burst_done;
  logic [SIG_W-1:0] burst_count;

  // ==========================================================
  // Oscillator tick, one pulse per 500 kHz period
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == TICK_LAST) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ==========================================================
  // Register bus decode
  wire req = avs_read | avs_write;
  wire wr_now = avs_write & ack;
  wire cfg_we = wr_now && (avs_address == REG_CONFIG) && avs_byteenable[0];
  wire deb_hit = wr_now && (avs_address == REG_DEBOUNCE);
  wire ddc_we = deb_hit && avs_byteenable[0];
  wire exit_debounce_count_we = deb_hit && avs_byteenable[1];
  wire [SIG_W-1:0] ref_val = ref_acc[ACC_W-1 -: SIG_W];
  wire [31:0] status_word = {29'h0000000, thaw, calibrating, detected};
  wire [31:0] rd_mux =
    (avs_address == REG_CONFIG) ? {24'h000000, cfg} :
    (avs_address == REG_STATUS) ? status_word :
    (avs_address == REG_SIGNAL) ? {16'h0000, sig} :
    (avs_address == REG_REFERENCE) ? {16'h0000, ref_val} :
    (avs_address == REG_DEBOUNCE) ? {16'h0000, exit_debounce_count, ddc} : 32'h00000000;
  assign avs_waitrequest = req & ~ack;

  // One wait cycle per access; read data latched in that cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) avs_readdata <= rd_mux;
    end
  end

  // Configuration and debounce registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= CFG_RESET;
      ddc <= DDC_RESET;
      exit_debounce_count <= EXIT_DEBOUNCE_COUNT_RESET;
    end else begin
      if (cfg_we) cfg <= avs_writedata[7:0];
      if (ddc_we) ddc <= avs_writedata[DDC_LSB +: DEB_W];
      if (exit_debounce_count_we) exit_debounce_count <= avs_writedata[EXIT_DEBOUNCE_COUNT_LSB +: DEB_W];
    end
  end

  // ==========================================================
  // Acquisition datapath
  wire upd = (sq == SQ_UPDATE);
  wire sample = upd && !calibrating;
  wire cal_last = calibrating && (cal_n == CAL_LAST);
  wire filter_run = !detected || thaw;
  wire [SIG_W:0] margin = {1'b0, ref_val} - {1'b0, sig};
  wire thr_prox = (cfg.mode == MODE_PROX);
  wire [1:0] thr_idx = {thr_prox, cfg.thr[0]};
  wire [SIG_W-1:0] thr_val =
    (thr_idx == 2'h0) ? (ref_val >> THR_REL_SH0) :
    (thr_idx == 2'h1) ? (ref_val >> THR_REL_SH1) :
    (thr_idx == 2'h2) ? THR_ABS0 : THR_ABS1;
  wire cand = !margin[SIG_W] && (margin[SIG_W-1:0] >= thr_val);
  // The arithmetic shift rounds toward minus infinity, so a falling signal
  // always pulls the reference down by at least one fractional step
  wire signed [ACC_W:0] err =
    $signed({1'b0, sig, {FRAC_W{1'b0}}}) - $signed({1'b0, ref_acc});
  wire signed [ACC_W:0] step = err >>> FILT_SHIFT;
  wire [ACC_W-1:0] ref_filt = ref_acc + step[ACC_W-1:0];
  wire [SUM_W-1:0] cal_total = cal_sum + {{CAL_SH{1'b0}}, sig};
  wire [SIG_W-1:0] cal_ref = cal_total[SUM_W-1 -: SIG_W];
  wire [SIG_W-1:0] frz_lim = freeze_limit(cfg.freeze);
  wire [SIG_W-1:0] frz_next = frz_cnt + 1'b1;
  wire [SIG_W-1:0] gap_load =
    (calibrating && !cal_last) ? GAP_NORMAL : gap_ticks(cfg.power);

  // ==========================================================
  // Sequencer: launch, burst, update, gap
  always_comb begin
    next_sq = sq;
    case (sq)
      SQ_LAUNCH: next_sq = SQ_BURST;
      SQ_BURST: begin
        if (burst_done) next_sq = SQ_UPDATE;
      end
      SQ_UPDATE: next_sq = SQ_GAP;
      SQ_GAP: begin
        if (tick && gap_cnt == '0) next_sq = SQ_LAUNCH;
      end
      default: next_sq = SQ_LAUNCH;
    endcase
  end

  // State, gap timer and signal capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sq <= SQ_LAUNCH;
      gap_cnt <= '0;
      sig <= '0;
    end else begin
      sq <= next_sq;
      if (upd) gap_cnt <= gap_load;
      else if (sq == SQ_GAP && tick) gap_cnt <= gap_cnt - 1'b1;
      if (burst_done) sig <= burst_count;
    end
  end

  // Calibration accumulates bursts, then seeds the reference
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_sum <= '0;
      cal_n <= '0;
      calibrating <= 1'b1;
    end else if (upd && calibrating) begin
      cal_sum <= cal_last ? '0 : cal_total;
      cal_n <= cal_n + 1'b1;
      if (cal_last) calibrating <= 1'b0;
    end
  end

  // Reference: seeded by calibration, then filtered unless frozen
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_acc <= '0;
    end else if (upd && cal_last) begin
      ref_acc <= {cal_ref, {FRAC_W{1'b0}}};
    end else if (sample && filter_run) begin
      ref_acc <= ref_filt;
    end
  end

  // Freeze timer runs while a detection holds the reference
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frz_cnt <= '0;
      thaw <= 1'b0;
    end else if (!detected) begin
      frz_cnt <= '0;
      thaw <= 1'b0;
    end else if (sample && !thaw) begin
      frz_cnt <= frz_next;
      if (frz_next >= frz_lim) thaw <= 1'b1;
    end
  end

  // Reported state on the pin
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) detect_output <= 1'b0;
    else detect_output <= detected;
  end

  // ==========================================================
  // Submodules
  ctd_burst #(.CNT_W(SIG_W)) u_burst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .start(sq == SQ_LAUNCH),
    .trip_level_in(trip_level_in),
    .fe(fe),
    .done(burst_done),
    .count(burst_count)
  );

  ctd_debounce #(.CNT_W(DEB_W)) u_deb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sample(sample),
    .cond(cand),
    .entry_need(ddc),
    .exit_need(exit_debounce_count),
    .active(detected)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_cal_final;
    upd && cal_last;
  endsequence
  sequence s_frozen_sample;
    sample && detected && !thaw;
  endsequence

  AST_SIG_CAPTURE: assert property (
    burst_done |=> sig == $past(burst_count))
    else $error("signal not taken from burst count");
  AST_CAL_END: assert property (
    s_cal_final |=> !calibrating && ref_val == $past(cal_ref))
    else $error("calibration did not seed reference");
  AST_CAL_NO_DETECT: assert property (
    calibrating |-> !detected && !detect_output)
    else $error("detection during calibration");
  AST_CAL_NORMAL: assert property (
    (upd && calibrating && !cal_last) |=> gap_cnt == GAP_NORMAL)
    else $error("low power gap used in calibration");
  AST_LP_GAP: assert property (
    (upd && !calibrating) |=> gap_cnt == gap_ticks($past(cfg.power)))
    else $error("configured power gap not applied");
  AST_DETECT_CAUSE: assert property (
    $rose(detected) |-> $past(cand) && $past(sample))
    else $error("detection without candidate");
  AST_TRACK_UP: assert property (
    (sample && filter_run && err > 0) |=> ref_acc >= $past(ref_acc))
    else $error("reference moved away from signal");
  AST_FREEZE: assert property (
    s_frozen_sample |=> $stable(ref_acc))
    else $error("reference changed while frozen");
  AST_THAW: assert property (
    (s_frozen_sample and (frz_next >= frz_lim)) |=> thaw ##1 thaw)
    else $error("freeze timeout did not release filter");
  AST_OUT: assert property (
    detected |=> detect_output)
    else $error("detect output not high");
  AST_OUT_LOW: assert property (
    !detected |=> !detect_output)
    else $error("detect output high without detection");
  // Once detection has ended the filter restarts from the held value
  AST_RESUME: assert property (
    (sample && !detected) |=> ref_acc == $past(ref_filt))
    else $error("filter did not resume from held reference");
endmodule // ctd_top

// ### testbench/ctd_fe_model.sv
// Front end model: counts transfer pulses and trips the comparator.
// Assumes fe comes from the burst engine and target is set by the bench.
module ctd_fe_model
  import ctd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ctd_pkg::ctd_fe_t fe,
  input wire logic [15:0] target,
  output logic trip_level_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] n_xfer;
  logic xfer_q;
  // Discharge empties the sampling cap; each transfer adds charge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      n_xfer <= 16'h0000;
      xfer_q <= 1'b0;
      trip_level_in <= 1'b0;
    end else begin
      xfer_q <= fe.transfer;
      if (fe.discharge) begin
        n_xfer <= 16'h0000;
        trip_level_in <= 1'b0;
      end else if (fe.transfer && !xfer_q) begin
        n_xfer <= n_xfer + 16'h0001;
        // Trip early in the last transfer so it is stable before the tick
        trip_level_in <= (n_xfer + 16'h0001 >= target);
      end
    end
  end
endmodule // ctd_fe_model

// ### testbench/tb.sv
// Bench: Avalon-MM master, front end model and read-data scoreboard.
// Assumes ctd_top shortened to a calibration of 4 bursts.
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ctd_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ctd_fe_t fe;
  logic trip_level_in;
  logic detect_output;
  logic [15:0] target = 16'h0008;
  logic [31:0] exp_q[$];
  logic [31:0] e_cur;
  int n_mismatch = 0;
  int compares = 0;
  int nbursts = 0;
  int gap_cyc = 0;
  int last_gap = 0;
  // ==========================================================
  // Clock, design and far side
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ctd_top #(.CAL_COUNT(4)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fe(fe), .trip_level_in(trip_level_in), .detect_output(detect_output)
  );
  ctd_fe_model i_fe (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .fe(fe), .target(target),
    .trip_level_in(trip_level_in)
  );
  // Count burst starts and time the idle gap before each one
  always @(posedge ref_clk) begin
    if (fe.discharge) begin
      gap_cyc <= gap_cyc + 1;
    end else if (gap_cyc != 0) begin
      last_gap <= gap_cyc;
      gap_cyc <= 0;
      nbursts <= nbursts + 1;
    end
  end
  // Compare each completed read with the oldest note, at its final edge
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
      end else begin
        e_cur = exp_q.pop_front();
        `CHK(avs_readdata, e_cur)
      end
    end
  end
  // ==========================================================
  // Bus master, waits and verdict
  task automatic acc(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Hold the request until waitrequest is seen low at a rising edge
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge so the next call never reassigns in this time step
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0, 4'hf);
  endtask
  // Wait until k more bursts have started, bounded
  task automatic wait_bursts(input int k);
    int t;
    int i;
    t = nbursts + k;
    for (i = 0; i < 40000 && nbursts < t; i++) @(posedge ref_clk);
    if (nbursts < t) n_mismatch++;
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog for a hung handshake or a burst that never ends
  initial begin
    #900_000;
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(41970));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(REG_CONFIG, 32'h0);
    rd(REG_STATUS, 32'h2);
    rd(REG_DEBOUNCE, 32'h0403);
    acc(1'b1, 5'h14, $urandom(), 4'hf);
    acc(1'b1, REG_STATUS, $urandom(), 4'hf);
    rd(5'h14, 32'h0);
    rd(REG_STATUS, 32'h2);
    acc(1'b1, REG_CONFIG, 32'h51, 4'hf);
    rd(REG_CONFIG, 32'h51);
    acc(1'b1, REG_DEBOUNCE, 32'h0902, 4'h1);
    rd(REG_DEBOUNCE, 32'h0402);
    acc(1'b1, REG_DEBOUNCE, 32'h0100, 4'h2);
    rd(REG_DEBOUNCE, 32'h0102);
    // Low power is ignored while calibrating, used afterwards
    wait_bursts(3);
    `CHK(last_gap >= 800 && last_gap <= 1300, 1'b1)
    wait_bursts(1);
    `CHK(last_gap >= 12600, 1'b1)
    acc(1'b1, REG_CONFIG, 32'h11, 4'hf);
    wait_bursts(1);
    target <= 16'h0003;
    rd(REG_STATUS, 32'h0);
    rd(REG_REFERENCE, 32'h8);
    rd(REG_SIGNAL, 32'h8);
    // One qualifying sample is not enough with an entry count of 2
    wait_bursts(1);
    `CHK(detect_output, 1'b0)
    rd(REG_SIGNAL, 32'h3);
    wait_bursts(1);
    `CHK(detect_output, 1'b1)
    rd(REG_STATUS, 32'h1);
    // Three detected samples would pull a live reference to 6
    wait_bursts(3);
    target <= 16'h000c;
    rd(REG_REFERENCE, 32'h7);
    wait_bursts(1);
    `CHK(detect_output, 1'b0)
    wait_bursts(3);
    rd(REG_REFERENCE, 32'h8);
    // Absolute level 8 rejects a drop of 4 even with entry count 1
    target <= 16'h0004;
    acc(1'b1, REG_CONFIG, 32'h01, 4'hf);
    acc(1'b1, REG_DEBOUNCE, 32'h0101, 4'h3);
    wait_bursts(1);
    `CHK(detect_output, 1'b0)
    close_out();
  end
endmodule // tb
